//--- src/vapc_pkg.sv
// Purpose: constants for voice activity power control
// Assumes: byte-wide register port after the I2C control front end
// Notes:   one name per offset, field, reset value and timing count
// Functional notes
// R1: policy 0 host only, 1 detector both ways
// R2: policy 2 detector up, 3 detector down
// R3: two-bit channel select, reset selects channel 2
// R4: clock source internal, bit or master clock
// R5: source code 3 uses custom clock tick
// R6: declared external rate must match supplied clock
// R7: pin carries interrupt when enabled, not recording
// R8: detection during recording only when bit set
// R9: host writes reset values into reserved bits
// R10: detection runs only while global enable set
// R11: config registers reachable only on page 1
// R12: interrupt on activity onset drives auto power
package vapc_pkg;
  localparam logic [7:0] VAPC_PAGE_OFS   = 8'h00;
  localparam logic [7:0] VAPC_CFG_A_OFS  = 8'h1E;
  localparam logic [7:0] VAPC_CFG_B_OFS  = 8'h1F;
  localparam logic [7:0] VAPC_CFG_PAGE   = 8'h01;
  localparam logic [7:0] VAPC_PAGE_RST   = 8'h00;
  localparam logic [7:0] VAPC_CFG_A_RST  = 8'h20;
  localparam logic [7:0] VAPC_CFG_B_RST  = 8'h08;
  localparam logic [7:0] VAPC_CFG_B_WMSK = 8'hD8;
  localparam logic [7:0] VAPC_UNMAPPED   = 8'h00;
  // field positions (low bit of each field)
  localparam int VAPC_POLICY_LSB = 6;
  localparam int VAPC_CHSEL_LSB  = 4;
  localparam int VAPC_CLKSRC_LSB = 2;
  localparam int VAPC_RATE_LSB   = 0;
  localparam int VAPC_PINIRQ_BIT = 6;
  localparam int VAPC_DWR_BIT    = 3;
  // timing: detector tick near the lowest declared rate
  localparam int VAPC_CLK_KHZ    = 250000;
  localparam int VAPC_DET_KHZ    = 3072;
  localparam int VAPC_OSC_DIV    = VAPC_CLK_KHZ / VAPC_DET_KHZ;
  typedef enum logic [1:0] {
    VAPC_POL_HOST = 2'h0, VAPC_POL_AUTO = 2'h1,
    VAPC_POL_UP   = 2'h2, VAPC_POL_DOWN = 2'h3
  } vapc_policy_t;
  typedef enum logic [1:0] {
    VAPC_SRC_OSC = 2'h0, VAPC_SRC_BCLK = 2'h1,
    VAPC_SRC_MCLK = 2'h2, VAPC_SRC_CUSTOM = 2'h3
  } vapc_src_t;
  typedef enum logic {VAPC_PWR_OFF = 1'b0, VAPC_PWR_ON = 1'b1} vapc_pwr_t;
  // external edges per detector tick for each declared rate
  function automatic logic [2:0] vapc_ext_div(input logic [1:0] rate);
    case (rate)
      2'h0:    vapc_ext_div = 3'h1;
      2'h1:    vapc_ext_div = 3'h2;
      2'h2:    vapc_ext_div = 3'h4;
      default: vapc_ext_div = 3'h6;
    endcase
  endfunction
endpackage

//--- src/vapc_tick.sv
// Purpose: detector tick enable from the selected clock source
// Assumes: bit and master clock inputs are synchronous samples
// Notes:   external edges are divided to a common detector rate
`timescale 1ns/10ps
`default_nettype none
module vapc_tick #(
  parameter int OSC_DIV = vapc_pkg::VAPC_OSC_DIV
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             nrst_in,
  // source selection
  input  wire vapc_pkg::vapc_src_t src_in,
  input  wire logic [1:0]       rate_in,
  // clock sources
  input  wire logic             bclk_in,
  input  wire logic             mclk_in,
  input  wire logic             custom_tick_in,
  // tick out
  output logic                  tick_out
);
  import vapc_pkg::*;
  initial if (OSC_DIV < 2 || OSC_DIV > 255)
    $error("OSC_DIV out of range");
  typedef struct packed {
    logic [7:0] osc_cnt;
    logic [2:0] edge_cnt;
    logic       ext_prev;
    logic       tick;
  } vapc_tick_st_t;
  vapc_tick_st_t st_reg, st_next;
  logic ext_lvl;

  // pick source, divide, produce one-cycle tick
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    ext_lvl = (src_in == VAPC_SRC_MCLK) ? mclk_in : bclk_in;
    st_next.ext_prev = ext_lvl;
    unique case (src_in)
      VAPC_SRC_OSC: begin // R4
        if (st_reg.osc_cnt == 8'(OSC_DIV - 1)) begin
          st_next.osc_cnt = 8'h00;
          st_next.tick = 1'b1;
        end else begin
          st_next.osc_cnt = st_reg.osc_cnt + 8'h01;
        end
      end
      VAPC_SRC_BCLK, VAPC_SRC_MCLK: begin // R4 R6
        if (ext_lvl && !st_reg.ext_prev) begin
          if (st_reg.edge_cnt >= vapc_ext_div(rate_in) - 3'h1) begin
            st_next.edge_cnt = 3'h0;
            st_next.tick = 1'b1;
          end else begin
            st_next.edge_cnt = st_reg.edge_cnt + 3'h1;
          end
        end
      end
      VAPC_SRC_CUSTOM: st_next.tick = custom_tick_in; // R5
    endcase
  end

  // state register
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign tick_out = st_reg.tick;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  a_osc_period: assert property ( // R4
    src_in == VAPC_SRC_OSC && st_reg.osc_cnt == 8'h00 &&
    $past(src_in) == VAPC_SRC_OSC && $past(st_reg.osc_cnt) != 8'h00
    |-> tick_out)
    else $error("oscillator tick missing at wrap");
endmodule // vapc_tick
`default_nettype wire

//--- src/vapc_top.sv
// Purpose: voice activity detector configuration and power control
// Assumes: register port is the decoded side of the I2C control port
// Notes:   reads answer one cycle after the strobe, unmapped read 0x00
`timescale 1ns/10ps
`default_nettype none
module vapc_top #(
  parameter int NUM_CH  = 4,
  parameter int OSC_DIV = vapc_pkg::VAPC_OSC_DIV
) (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  // register port
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  output logic [7:0]             reg_rdata_out,
  output logic                   reg_rdvalid_out,
  // detector context
  input  wire logic              detector_global_enable_in,
  input  wire logic [NUM_CH-1:0] ch_activity_in,
  input  wire logic              recording_in,
  input  wire logic              host_power_up_in,
  input  wire logic              host_power_down_in,
  // clock sources
  input  wire logic              bclk_in,
  input  wire logic              mclk_in,
  input  wire logic              custom_tick_in,
  // results
  output logic                   channel_power_out,
  output logic                   detector_irq_out,
  output logic                   serial_data_out_pin_out,
  output logic                   serial_data_out_pin_oe_n_out
);
  import vapc_pkg::*;
  initial if (NUM_CH != 4) $error("NUM_CH must be 4");

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] rdata;
    logic       rdvalid;
    logic       act_prev;
    vapc_pwr_t  pwr;
    logic       irq;
    logic       pin;
    logic       pin_oe_n;
  } vapc_st_t;
  vapc_st_t st_reg, st_next;

  logic         tick;
  vapc_policy_t policy;
  vapc_src_t    src;
  logic [1:0]   chsel;
  logic         run, sel_act, onset, release_ev;
  logic         auto_up, auto_down, host_up, host_down;

  // detector clock tick from the selected source
  vapc_tick #(.OSC_DIV(OSC_DIV)) u_tick (
    .clock_in      (clock_in),
    .nrst_in       (nrst_in),
    .src_in        (src),
    .rate_in       (st_reg.cfg_a[VAPC_RATE_LSB +: 2]),
    .bclk_in       (bclk_in),
    .mclk_in       (mclk_in),
    .custom_tick_in(custom_tick_in),
    .tick_out      (tick)
  );

  // field decode
  always_comb begin
    policy = vapc_policy_t'(st_reg.cfg_a[VAPC_POLICY_LSB +: 2]);
    src    = vapc_src_t'(st_reg.cfg_a[VAPC_CLKSRC_LSB +: 2]);
    chsel  = st_reg.cfg_a[VAPC_CHSEL_LSB +: 2];
    sel_act = ch_activity_in[chsel]; // R3
    run = detector_global_enable_in && // R10
          (!recording_in || st_reg.cfg_b[VAPC_DWR_BIT]); // R8
    onset      = tick && run && sel_act && !st_reg.act_prev; // R12
    release_ev = tick && run && !sel_act && st_reg.act_prev;
    auto_up    = policy == VAPC_POL_AUTO || policy == VAPC_POL_UP; // R1 R2
    auto_down  = policy == VAPC_POL_AUTO || policy == VAPC_POL_DOWN;
    host_up    = policy == VAPC_POL_HOST || policy == VAPC_POL_DOWN;
    host_down  = policy == VAPC_POL_HOST || policy == VAPC_POL_UP;
  end

  // next state: registers, detector, power and pin
  always_comb begin
    st_next = st_reg;
    st_next.rdvalid = reg_rd_in;
    // register writes, page register on every page
    if (reg_wr_in) begin
      if (reg_addr_in == VAPC_PAGE_OFS) begin
        st_next.page = reg_wdata_in; // R11
      end else if (st_reg.page == VAPC_CFG_PAGE) begin // R11
        if (reg_addr_in == VAPC_CFG_A_OFS) begin
          st_next.cfg_a = reg_wdata_in;
        end else if (reg_addr_in == VAPC_CFG_B_OFS) begin
          st_next.cfg_b = reg_wdata_in & VAPC_CFG_B_WMSK; // R9
        end
      end
    end
    // register reads, answered one cycle later
    st_next.rdata = VAPC_UNMAPPED;
    if (reg_rd_in) begin
      if (reg_addr_in == VAPC_PAGE_OFS) begin
        st_next.rdata = st_reg.page;
      end else if (st_reg.page == VAPC_CFG_PAGE) begin // R11
        if (reg_addr_in == VAPC_CFG_A_OFS) begin
          st_next.rdata = st_reg.cfg_a;
        end else if (reg_addr_in == VAPC_CFG_B_OFS) begin
          st_next.rdata = st_reg.cfg_b;
        end
      end
    end
    // activity history, cleared while suspended
    if (!run) begin
      st_next.act_prev = 1'b0;
    end else if (tick) begin
      st_next.act_prev = sel_act;
    end
    st_next.irq = onset || release_ev; // R12
    // power transitions, power-up wins a same-cycle conflict
    if ((onset && auto_up) || (host_power_up_in && host_up)) begin // R1 R2
      st_next.pwr = VAPC_PWR_ON;
    end else if ((release_ev && auto_down) ||
                 (host_power_down_in && host_down)) begin // R1 R2
      st_next.pwr = VAPC_PWR_OFF;
    end
    // output pin carries the interrupt while not recording
    st_next.pin_oe_n = !(st_reg.cfg_b[VAPC_PINIRQ_BIT] &&
                         !recording_in); // R7
    st_next.pin = !st_next.pin_oe_n && st_next.irq; // R7
  end

  // state register
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg          <= '0;
      st_reg.page     <= VAPC_PAGE_RST;
      st_reg.cfg_a    <= VAPC_CFG_A_RST; // R3 R4
      st_reg.cfg_b    <= VAPC_CFG_B_RST; // R7 R8
      st_reg.pwr      <= VAPC_PWR_OFF;
      st_reg.pin_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_out                = st_reg.rdata;
  assign reg_rdvalid_out              = st_reg.rdvalid;
  assign channel_power_out            = st_reg.pwr;
  assign detector_irq_out             = st_reg.irq;
  assign serial_data_out_pin_out      = st_reg.pin;
  assign serial_data_out_pin_oe_n_out = st_reg.pin_oe_n;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  a_irq_onset: assert property (onset |=> detector_irq_out) // R12
    else $error("no interrupt after onset");
  a_auto_up: assert property ( // R1
    onset && auto_up |=> channel_power_out)
    else $error("auto power-up missing");
  a_auto_down: assert property ( // R2
    release_ev && auto_down && !(host_power_up_in && host_up)
    |=> !channel_power_out)
    else $error("auto power-down missing");
  a_host_only: assert property ( // R1
    policy == VAPC_POL_HOST && !host_power_up_in && !host_power_down_in
    |=> $stable(channel_power_out))
    else $error("power moved without host");
  a_up_host_down: assert property ( // R2
    policy == VAPC_POL_UP && !host_power_down_in && channel_power_out
    |=> channel_power_out)
    else $error("detector powered down in policy 2");
  a_enable_gate: assert property ( // R10
    !detector_global_enable_in |=> !detector_irq_out)
    else $error("interrupt while disabled");
  a_rec_suspend: assert property ( // R8
    recording_in && !st_reg.cfg_b[VAPC_DWR_BIT] |=> !detector_irq_out)
    else $error("interrupt during suspended recording");
  a_pin_drive: assert property ( // R7
    ##1 serial_data_out_pin_oe_n_out ==
    !($past(st_reg.cfg_b[VAPC_PINIRQ_BIT]) &&
    !$past(recording_in)))
    else $error("pin enable wrong");
  a_page_gate: assert property ( // R11
    reg_wr_in && st_reg.page != VAPC_CFG_PAGE &&
    reg_addr_in == VAPC_CFG_A_OFS |=> $stable(st_reg.cfg_a))
    else $error("config written off page 1");
  a_read_answer: assert property ( // R11
    reg_rd_in && reg_addr_in == VAPC_CFG_A_OFS &&
    st_reg.page == VAPC_CFG_PAGE && !reg_wr_in
    |=> reg_rdvalid_out && reg_rdata_out == $past(st_reg.cfg_a))
    else $error("config read wrong");
  a_chan_pick: assert property ( // R3
    tick && run |=> st_reg.act_prev == $past(ch_activity_in[chsel]))
    else $error("wrong channel monitored");
  a_reserved_ro: assert property ( // R9
    st_reg.cfg_b[5] == 1'b0 && st_reg.cfg_b[2:0] == 3'h0)
    else $error("read-only reserved bits set");
  a_pin_value: assert property ( // R7
    serial_data_out_pin_out ==
    (!serial_data_out_pin_oe_n_out && detector_irq_out))
    else $error("pin value wrong");
  a_down_host_up: assert property ( // R2
    policy == VAPC_POL_DOWN && !host_power_up_in && !channel_power_out
    |=> !channel_power_out)
    else $error("detector powered up in policy 3");
  a_no_spurious: assert property ( // R12
    !tick |=> !detector_irq_out)
    else $error("interrupt without detector tick");
  a_up_refused: assert property ( // R2
    policy == VAPC_POL_UP && host_power_up_in && !onset &&
    !channel_power_out |=> !channel_power_out)
    else $error("host power-up taken in policy 2");
  c_auto_up: cover property (onset && policy == VAPC_POL_AUTO);
  c_host_down: cover property (host_power_down_in && policy == VAPC_POL_UP);
  c_release: cover property (release_ev && policy == VAPC_POL_DOWN);
  c_pin_irq: cover property (serial_data_out_pin_out);
  c_custom: cover property (tick && src == VAPC_SRC_CUSTOM);
endmodule // vapc_top
`default_nettype wire

//--- sim/vapc_host.sv
// Purpose: host model on the decoded control port
// Assumes: one byte per strobe, read answer one cycle later
// Notes:   address and data show a changed value when released
`timescale 1ns/10ps
`default_nettype none
module vapc_host (
  // clock
  input  wire logic       clock_in,
  // register port
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rdvalid_in
);
  import vapc_pkg::*;
  // idle port values at time zero
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // one byte write, page register included
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == VAPC_CFG_B_OFS) ? (d & 8'h48) : d;
    @(negedge clock_in);
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = v;
    @(negedge clock_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~v;
  endtask
  // one byte read, unknown if no valid answer
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_in);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge clock_in);
    // answer stands only in the cycle after the strobe edge
    d = (rdvalid_in === 1'b1) ? rdata_in : 8'hXX;
    rd_out = 1'b0;
    addr_out = ~a;
  endtask
endmodule // vapc_host
`default_nettype wire

//--- sim/vapc_top_tb.sv
// Purpose: self-checking bench for voice activity power control
// Assumes: oscillator detector tick shortened to four clocks
// Notes:   inputs change on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module vapc_top_tb;
  import vapc_pkg::*;
  logic       clock_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       reg_wr, reg_rd, rdvalid, power, irq, pin, pin_oe_n;
  logic [7:0] reg_addr, reg_wdata, rdata, rd_val, cfg_a, cfg_b;
  logic       enable = 1'b0, recording = 1'b0, up = 1'b0, down = 1'b0;
  logic [3:0] act = 4'h0, m, others;
  logic       bclk = 1'b0, mclk = 1'b0, ctick = 1'b0, exp_pwr = 1'b0;
  logic [1:0] pol;
  integer     fails = 0, comparisons = 0, seed = 32'h4138, cyc = 0, tmp;
  // clock, clock sources and hang limit
  always #2 clock_in = ~clock_in;
  always @(negedge clock_in) begin
    bclk <= ~bclk;
    mclk <= cyc[1];
    ctick <= (cyc[2:0] == 3'h0);
  end
  always @(posedge clock_in) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end
  vapc_host host (.clock_in(clock_in), .wr_out(reg_wr), .rd_out(reg_rd),
    .addr_out(reg_addr), .wdata_out(reg_wdata), .rdata_in(rdata),
    .rdvalid_in(rdvalid));
  vapc_top #(.OSC_DIV(4)) uut (.clock_in(clock_in), .nrst_in(nrst_in),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata),
    .reg_rdvalid_out(rdvalid), .detector_global_enable_in(enable),
    .ch_activity_in(act), .recording_in(recording),
    .host_power_up_in(up), .host_power_down_in(down), .bclk_in(bclk),
    .mclk_in(mclk), .custom_tick_in(ctick), .channel_power_out(power),
    .detector_irq_out(irq), .serial_data_out_pin_out(pin),
    .serial_data_out_pin_oe_n_out(pin_oe_n));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait for a detector pulse, then check power and pin in that cycle
  task automatic wait_irq();
    for (int i = 0; i < 400; i++) begin
      @(negedge clock_in);
      if (irq === 1'b1) break;
    end
    chk({7'h0, irq}, 8'h01);
    chk({7'h0, power}, {7'h0, exp_pwr});
    chk({6'h0, pin_oe_n, pin}, (cfg_b[6] && !recording) ? 8'h01 : 8'h02);
  endtask
  // no pulse may appear for n cycles
  task automatic quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(negedge clock_in);
      if (irq !== 1'b0) hits++;
    end
    chk(hits[7:0], 8'h00);
  endtask
  // host command pulse, expected power from the policy
  task automatic host_cmd(input logic u, input logic d);
    if (u && (pol == 2'h0 || pol == 2'h3)) exp_pwr = 1'b1;
    else if (d && (pol == 2'h0 || pol == 2'h2)) exp_pwr = 1'b0;
    @(negedge clock_in);
    up = u;
    down = d;
    @(negedge clock_in);
    up = 1'b0;
    down = 1'b0;
    chk({7'h0, power}, {7'h0, exp_pwr});
  endtask
  task automatic end_sim();
    $display("counts: comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge clock_in);
    nrst_in = 1'b1;
    chk({4'h0, power, irq, pin, pin_oe_n}, 8'h01);
    host.rd_reg(VAPC_CFG_A_OFS, rd_val);
    chk(rd_val, 8'h00);
    host.wr_reg(VAPC_PAGE_OFS, VAPC_CFG_PAGE);
    host.rd_reg(VAPC_PAGE_OFS, rd_val);
    chk(rd_val, VAPC_CFG_PAGE);
    host.rd_reg(VAPC_CFG_A_OFS, rd_val);
    chk(rd_val, VAPC_CFG_A_RST);
    host.rd_reg(VAPC_CFG_B_OFS, rd_val);
    chk(rd_val, VAPC_CFG_B_RST);
    host.rd_reg(8'h1D, rd_val);
    chk(rd_val, VAPC_UNMAPPED);
    act = 4'hF;
    quiet(60);
    act = 4'h0;
    $display("test reset and paging done");
    enable = 1'b1;
    for (int p = 0; p < 4; p++) begin
      // quiet lines first so a new channel choice sees no stale activity
      act = 4'h0;
      pol = p[1:0];
      tmp = $random(seed);
      m = 4'h1 << tmp[1:0];
      others = tmp[11:8] & ~m;
      cfg_a = {pol, tmp[1:0], pol, tmp[3:2]};
      cfg_b = {1'b0, p[0] | (p[1] & tmp[4]), 2'b00, 1'b1, 3'b000};
      host.wr_reg(VAPC_CFG_A_OFS, cfg_a);
      host.wr_reg(VAPC_CFG_B_OFS, cfg_b);
      host.rd_reg(VAPC_CFG_A_OFS, rd_val);
      chk(rd_val, cfg_a);
      act = others;
      quiet(40);
      if (pol == 2'h1 || pol == 2'h2) exp_pwr = 1'b1;
      act = others | m;
      wait_irq();
      if (pol == 2'h1 || pol == 2'h3) exp_pwr = 1'b0;
      act = others;
      wait_irq();
      host_cmd(1'b1, 1'b0);
      host_cmd(1'b0, 1'b1);
      $display("test policy %0d done", p);
    end
    recording = 1'b1;
    cfg_b = 8'h40;
    host.wr_reg(VAPC_CFG_B_OFS, cfg_b);
    act = others | m;
    quiet(60);
    chk({7'h0, pin_oe_n}, 8'h01);
    act = others;
    cfg_b = 8'h48;
    host.wr_reg(VAPC_CFG_B_OFS, cfg_b);
    act = others | m;
    wait_irq();
    $display("test recording done");
    enable = 1'b0;
    act = others;
    quiet(60);
    chk({7'h0, power}, {7'h0, exp_pwr});
    $display("test disable done");
    end_sim();
  end
endmodule // vapc_top_tb
`default_nettype wire
